// file: design/pwp_pkg.sv
// Constants, layouts and access decoding for the parameter write-protect bank
package pwp_pkg;

    // ==========================================
    // Widths and group codes
    localparam int          PARAM_W    = 16;
    localparam int          NUM_W      = 5;
    localparam int          GRP_W      = 3;
    localparam int          GRP_DEPTH  = 32;
    localparam int          N_EXT_GRP  = 4;
    localparam int          N_BASIC    = 10;
    localparam int          SLOT_W     = 4;

    localparam logic [GRP_W-1:0] GRP_BASIC   = 3'h0;
    localparam logic [GRP_W-1:0] GRP_GAIN    = 3'h1;
    localparam logic [GRP_W-1:0] GRP_EXT     = 3'h2;
    localparam logic [GRP_W-1:0] GRP_IO      = 3'h3;
    localparam logic [GRP_W-1:0] GRP_LINEAR  = 3'h4;

    // ==========================================
    // Write-protect levels
    localparam logic [PARAM_W-1:0] WP_BASIC     = 16'h0000;
    localparam logic [PARAM_W-1:0] WP_GAIN_EXT  = 16'h000B;
    localparam logic [PARAM_W-1:0] WP_IO        = 16'h000C;
    localparam logic [PARAM_W-1:0] WP_FULL      = 16'h000D;
    localparam logic [PARAM_W-1:0] WP_LOCK_BAS  = 16'h100B;
    localparam logic [PARAM_W-1:0] WP_LOCK_ALL  = 16'h100D;

    // ==========================================
    // Apply classes of a parameter
    localparam logic [1:0] CLS_NONE  = 2'h0;
    localparam logic [1:0] CLS_STAR  = 2'h1;
    localparam logic [1:0] CLS_DSTAR = 2'h2;

    // ==========================================
    // Basic group table, slot 9 first
    // Slots: 02 braking, 03 retention, 04 func a1, 08 tuning sel, 09 response,
    //        10 in-position, 14 direction, 15 enc pulses, 16 enc pulses two, 19 protect
    localparam logic [N_BASIC-1:0][NUM_W-1:0] BASIC_NUM = {
        5'h13, 5'h10, 5'h0F, 5'h0E, 5'h0A, 5'h09, 5'h08, 5'h04, 5'h03, 5'h02};
    localparam logic [N_BASIC-1:0][PARAM_W-1:0] BASIC_RST = {
        16'h000D, 16'h0000, 16'h0FA0, 16'h0000, 16'h0064,
        16'h000C, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [N_BASIC-1:0][1:0] BASIC_CLS = {
        CLS_STAR, CLS_STAR, CLS_STAR, CLS_STAR, CLS_NONE,
        CLS_NONE, CLS_NONE, CLS_STAR, CLS_STAR, CLS_DSTAR};
    localparam logic [SLOT_W-1:0] SLOT_WP     = 4'h9;
    localparam logic [SLOT_W-1:0] SLOT_RETAIN = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_BRAKE  = 4'h0;

    // ==========================================
    // Register bus request
    typedef struct packed {
        logic [GRP_W-1:0]   grp;
        logic [NUM_W-1:0]   num;
        logic [PARAM_W-1:0] wdata;
        logic               wr;
        logic               rd;
    } pwp_req_s;

    // Group readable under a level
    function automatic logic pwp_read_ok(input logic [PARAM_W-1:0] lvl, input logic [GRP_W-1:0] grp);
        case (lvl)
            WP_BASIC, WP_LOCK_BAS: pwp_read_ok = (grp == GRP_BASIC);
            WP_GAIN_EXT:           pwp_read_ok = (grp <= GRP_EXT);
            WP_IO:                 pwp_read_ok = (grp <= GRP_IO);
            WP_FULL, WP_LOCK_ALL:  pwp_read_ok = (grp <= GRP_LINEAR);
            default:               pwp_read_ok = 1'b0;
        endcase
    endfunction

    // Group writable under a level; locked levels pass only the protect setting
    function automatic logic pwp_write_ok(input logic [PARAM_W-1:0] lvl, input logic [GRP_W-1:0] grp,
                                          input logic is_wp);
        case (lvl)
            WP_LOCK_BAS, WP_LOCK_ALL: pwp_write_ok = is_wp;
            WP_BASIC, WP_GAIN_EXT, WP_IO, WP_FULL: pwp_write_ok = pwp_read_ok(lvl, grp);
            default:                  pwp_write_ok = is_wp;
        endcase
    endfunction

endpackage

// file: design/pwp_param_cell.sv
// One parameter: stored value plus the value in force
`timescale 1ns/1ns
module pwp_param_cell
    import pwp_pkg::*;
#(
    parameter logic [PARAM_W-1:0] RST_VAL = 16'h0000,
    parameter logic [1:0]         CLS     = CLS_NONE
)
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               wr_en,
    input  wire logic [PARAM_W-1:0] wr_data,
    input  wire logic               apply_ctrl,
    input  wire logic               apply_power,
    output logic      [PARAM_W-1:0] stored,
    output logic      [PARAM_W-1:0] active
);

    logic [PARAM_W-1:0] stored_q;
    logic [PARAM_W-1:0] stored_d;
    logic [PARAM_W-1:0] active_q;
    logic [PARAM_W-1:0] active_d;

    always_comb
    begin
        stored_d = wr_en ? wr_data : stored_q;
        case (CLS)
            CLS_NONE:  active_d = stored_d;
            CLS_STAR:  active_d = (apply_ctrl || apply_power) ? stored_q : active_q;
            CLS_DSTAR: active_d = apply_power ? stored_q : active_q;
            default:   active_d = active_q;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stored_q <= RST_VAL;
            active_q <= RST_VAL;
        end
        else
        begin
            stored_q <= stored_d;
            active_q <= active_d;
        end
    end

    assign stored = stored_q;
    assign active = active_q;

endmodule // pwp_param_cell

// file: design/pwp_param_bank.sv
// Parameter store with group write protection and deferred apply
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ns
module pwp_param_bank
    import pwp_pkg::*;
(
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    input  wire pwp_req_s                            bus_req,
    input  wire logic                                ctrl_reset_pin,
    input  wire logic                                power_cycle_pin,
    output logic      [PARAM_W-1:0]                  rd_data_q,
    output logic                                     access_refused_q,
    output logic      [PARAM_W-1:0]                  wp_level_q,
    output logic                                     apply_pending_q,
    output logic      [N_BASIC-1:0][PARAM_W-1:0]     basic_active
);

    // ==========================================
    // Pin synchronisers and apply pulses
    logic [2:0] ctrl_sync_q;
    logic [2:0] ctrl_sync_d;
    logic [2:0] pwr_sync_q;
    logic [2:0] pwr_sync_d;
    logic       apply_ctrl;
    logic       apply_power;

    always_comb
    begin
        ctrl_sync_d = {ctrl_sync_q[1:0], ctrl_reset_pin};
        pwr_sync_d  = {pwr_sync_q[1:0], power_cycle_pin};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_sync_q <= 3'h0;
            pwr_sync_q  <= 3'h0;
        end
        else
        begin
            ctrl_sync_q <= ctrl_sync_d;
            pwr_sync_q  <= pwr_sync_d;
        end
    end

    assign apply_ctrl  = ctrl_sync_q[1] & ~ctrl_sync_q[2];
    assign apply_power = pwr_sync_q[1] & ~pwr_sync_q[2];

    // ==========================================
    // Address decode
    function automatic logic [SLOT_W:0] basic_slot(input logic [NUM_W-1:0] num);
        basic_slot = {1'b0, 4'h0};
        for (int i = 0; i < N_BASIC; i++)
        begin
            if (BASIC_NUM[i] == num)
                basic_slot = {1'b1, SLOT_W'(i)};
        end
    endfunction

    logic [SLOT_W:0]    hit;
    logic               is_basic;
    logic               is_wp;
    logic               grp_valid;
    logic               rd_ok;
    logic               wr_ok;
    logic [PARAM_W-1:0] wp_active;

    always_comb
    begin
        hit       = basic_slot(bus_req.num);
        is_basic  = (bus_req.grp == GRP_BASIC);
        is_wp     = is_basic && hit[SLOT_W] && (hit[SLOT_W-1:0] == SLOT_WP);
        grp_valid = (bus_req.grp <= GRP_LINEAR) && (!is_basic || hit[SLOT_W]);
        // Access follows the level in force, never the one just written
        rd_ok = bus_req.rd && grp_valid && pwp_read_ok(wp_active, bus_req.grp);
        wr_ok = bus_req.wr && grp_valid && pwp_write_ok(wp_active, bus_req.grp, is_wp);
    end

    // ==========================================
    // Basic group cells
    logic [N_BASIC-1:0][PARAM_W-1:0] basic_stored;
    logic [N_BASIC-1:0]              cell_wr;

    generate
        for (genvar g = 0; g < N_BASIC; g++)
        begin : g_basic
            assign cell_wr[g] = wr_ok && is_basic && (hit[SLOT_W-1:0] == SLOT_W'(g));
            pwp_param_cell #(
                .RST_VAL (BASIC_RST[g]),
                .CLS     (BASIC_CLS[g])
            ) u_cell (
                .clk         (clk),
                .rst_n       (rst_n),
                .wr_en       (cell_wr[g]),
                .wr_data     (bus_req.wdata),
                .apply_ctrl  (apply_ctrl),
                .apply_power (apply_power),
                .stored      (basic_stored[g]),
                .active      (basic_active[g])
            );
        end
    endgenerate

    assign wp_active = basic_active[SLOT_WP];

    // ==========================================
    // Other groups: immediate-use words
    logic [PARAM_W-1:0] grp_mem [N_EXT_GRP][GRP_DEPTH];
    logic [1:0]         mem_grp;

    assign mem_grp = 2'(bus_req.grp - GRP_GAIN);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int a = 0; a < N_EXT_GRP; a++)
                for (int b = 0; b < GRP_DEPTH; b++)
                    grp_mem[a][b] <= 16'h0000;
        end
        else if (wr_ok && !is_basic)
        begin
            grp_mem[mem_grp][bus_req.num] <= bus_req.wdata;
        end
    end

    // ==========================================
    // Read answer, refusal and status
    logic [PARAM_W-1:0] rd_data_d;
    logic               refused_d;
    logic               pending_d;

    always_comb
    begin
        rd_data_d = 16'h0000;
        if (rd_ok)
            rd_data_d = is_basic ? basic_stored[hit[SLOT_W-1:0]] : grp_mem[mem_grp][bus_req.num];
        refused_d = (bus_req.rd && !rd_ok) || (bus_req.wr && !wr_ok);
        pending_d = (basic_stored != basic_active);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q        <= 16'h0000;
            access_refused_q <= 1'b0;
            wp_level_q       <= WP_FULL;
            apply_pending_q  <= 1'b0;
        end
        else
        begin
            rd_data_q        <= rd_data_d;
            access_refused_q <= refused_d;
            wp_level_q       <= wp_active;
            apply_pending_q  <= pending_d;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic first_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end

    a_level_held_apply: assert property (!apply_ctrl && !apply_power |=> $stable(wp_active))
        else $error("protect level changed without reset");

    a_default_full_access: assert property (first_q |-> wp_active == WP_FULL
                                            && rd_ok == (bus_req.rd && grp_valid))
        else $error("protect level not full after reset");

    a_basic_only_lvl: assert property (wp_active == WP_BASIC && bus_req.wr && bus_req.grp != GRP_BASIC
                                       |=> access_refused_q)
        else $error("write outside basic group accepted");

    a_locked_write_block: assert property ((wp_active == WP_LOCK_BAS || wp_active == WP_LOCK_ALL)
                                           && bus_req.wr && !is_wp |=> $stable(basic_stored))
        else $error("locked level allowed a write");

    a_locked_read_all: assert property (wp_active == WP_LOCK_ALL && bus_req.rd && bus_req.grp == GRP_IO
                                        |=> !access_refused_q)
        else $error("locked level refused a read");

    a_star_value_held: assert property (!apply_ctrl && !apply_power |=> $stable(basic_active[SLOT_RETAIN]))
        else $error("single-star value applied early");

    a_dstar_ctrl_held: assert property (apply_ctrl && !apply_power |=> $stable(basic_active[SLOT_BRAKE]))
        else $error("double-star value applied on controller reset");

    a_refused_no_write: assert property (bus_req.wr && !wr_ok |=> $stable(basic_stored) && access_refused_q)
        else $error("refused write changed state");

    a_refused_read_zero: assert property (bus_req.rd && !rd_ok |=> rd_data_q == 16'h0000 ##1 1'b1)
        else $error("refused read returned data");

    a_wp_apply_ctrl: assert property (apply_ctrl && !cell_wr[SLOT_WP]
                                      |=> wp_active == $past(basic_stored[SLOT_WP]))
        else $error("protect setting not applied on controller reset");

    // ==========================================
    // Further access and apply checks
    logic wp_locked;

    // Either locked level in force
    assign wp_locked = (wp_active == WP_LOCK_BAS) || (wp_active == WP_LOCK_ALL);

    a_level_copy_out: assert property (1'b1 |=> wp_level_q == $past(wp_active))
        else $error("level output does not follow level in force");

    a_apply_pulse_short: assert property (apply_ctrl |=> !apply_ctrl)
        else $error("controller apply pulse longer than one cycle");

    a_idle_no_refuse: assert property (!bus_req.rd && !bus_req.wr |=> !access_refused_q)
        else $error("refusal without a request");

    a_idle_read_zero: assert property (!rd_ok |=> rd_data_q == 16'h0000)
        else $error("read data without an accepted read");

    a_bad_group_read: assert property (bus_req.rd && bus_req.grp > GRP_LINEAR |=> access_refused_q)
        else $error("read of unknown group accepted");

    a_full_write_ok: assert property (wp_active == WP_FULL && bus_req.wr && grp_valid
                                      |=> !access_refused_q)
        else $error("full access level refused a write");

    a_basic_lvl_read: assert property (wp_active == WP_BASIC && bus_req.rd && bus_req.grp != GRP_BASIC
                                       |=> access_refused_q)
        else $error("read outside basic group accepted");

    a_gain_ext_lvl: assert property (wp_active == WP_GAIN_EXT && bus_req.wr && bus_req.grp > GRP_EXT
                                     |=> access_refused_q)
        else $error("write above extension group accepted");

    a_io_lvl_write: assert property (wp_active == WP_IO && bus_req.wr && bus_req.grp == GRP_LINEAR
                                     |=> access_refused_q)
        else $error("write to linear group accepted at I/O level");

    a_io_lvl_read: assert property (wp_active == WP_IO && bus_req.rd && bus_req.grp == GRP_LINEAR
                                    |=> access_refused_q)
        else $error("read of linear group accepted at I/O level");

    a_lock_bas_read: assert property (wp_active == WP_LOCK_BAS && bus_req.rd && bus_req.grp != GRP_BASIC
                                      |=> access_refused_q)
        else $error("locked basic level accepted a read");

    a_lock_other_wr: assert property (wp_locked && bus_req.wr && bus_req.grp != GRP_BASIC
                                      |=> access_refused_q)
        else $error("locked level accepted a group write");

    a_lock_wp_write: assert property (wp_locked && bus_req.wr && is_wp |=> !access_refused_q)
        else $error("locked level refused the protect setting");

    a_star_ctrl_apply: assert property (apply_ctrl
                                        |=> basic_active[SLOT_RETAIN] == $past(basic_stored[SLOT_RETAIN]))
        else $error("single-star value not applied on controller reset");

    a_dstar_pwr_apply: assert property (apply_power
                                        |=> basic_active[SLOT_BRAKE] == $past(basic_stored[SLOT_BRAKE]))
        else $error("double-star value not applied on power cycle");

    a_group_mem_held: assert property (bus_req.wr && !wr_ok
                                       |=> grp_mem[$past(mem_grp)][$past(bus_req.num)]
                                           == $past(grp_mem[mem_grp][bus_req.num]))
        else $error("refused write changed a group word");

    c_write_refused:  cover property (bus_req.wr && !wr_ok);
    c_level_change:   cover property (apply_ctrl ##1 wp_active != $past(wp_active));
    c_locked_wp_wr:   cover property (wp_active == WP_LOCK_ALL && cell_wr[SLOT_WP]);
    c_power_apply:    cover property (apply_power && apply_pending_q);

endmodule // pwp_param_bank

// file: dv/pwp_ctrl_model.sv
// Controller model: drives parameter accesses and the apply pins
`timescale 1ns/1ns
module pwp_ctrl_model
    import pwp_pkg::*;
(
    input  wire logic               clk,
    input  wire logic [PARAM_W-1:0] rd_data_q,
    input  wire logic               access_refused_q,
    output pwp_req_s                bus_req,
    output logic                    ctrl_reset_pin,
    output logic                    power_cycle_pin
);
    initial
    begin
        bus_req         = '0;
        ctrl_reset_pin  = 1'b0;
        power_cycle_pin = 1'b0;
    end

    // ==========================================
    // One access; manufacturer numbers only used where refusal is expected
    task automatic access(input logic w, input logic [GRP_W-1:0] g, input logic [NUM_W-1:0] n,
                          input logic [PARAM_W-1:0] d, output logic [PARAM_W-1:0] q, output logic rf);
        @(posedge clk);
        bus_req <= '{grp: g, num: n, wdata: d, wr: w, rd: ~w};
        @(posedge clk);
        bus_req.wr    <= 1'b0;
        bus_req.rd    <= 1'b0;
        bus_req.wdata <= ~d;
        #1;
        q  = rd_data_q;
        rf = access_refused_q;
    endtask

    // ==========================================
    // Controller reset or power cycle, then settle
    task automatic apply(input logic pwr);
        @(posedge clk);
        if (pwr)
            power_cycle_pin <= 1'b1;
        else
            ctrl_reset_pin <= 1'b1;
        @(posedge clk);
        power_cycle_pin <= 1'b0;
        ctrl_reset_pin  <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule // pwp_ctrl_model

// file: dv/tb_pwp_param_bank.sv
// Testbench for the parameter write-protect bank
`timescale 1ns/1ns
module tb_pwp_param_bank
    import pwp_pkg::*;
;
    logic                            clk;
    logic                            rst_n;
    pwp_req_s                        bus_req;
    logic                            ctrl_reset_pin;
    logic                            power_cycle_pin;
    logic [PARAM_W-1:0]              rd_data_q;
    logic                            access_refused_q;
    logic [PARAM_W-1:0]              wp_level_q;
    logic                            apply_pending_q;
    logic [N_BASIC-1:0][PARAM_W-1:0] basic_active;
    int                              n_errors = 0;
    int                              check_count = 0;

    localparam logic [NUM_W-1:0]   RNUM [10] = '{5'h02, 5'h03, 5'h04, 5'h08, 5'h09, 5'h0A, 5'h0E, 5'h0F, 5'h10, 5'h13};
    localparam logic [PARAM_W-1:0] RVAL [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h000C,
                                                 16'h0064, 16'h0000, 16'h0FA0, 16'h0000, 16'h000D};
    localparam logic [PARAM_W-1:0] LVL [6] = '{16'h0000, 16'h000B, 16'h000C, 16'h000D, 16'h100B, 16'h100D};
    localparam logic [4:0]         RM [6]  = '{5'h01, 5'h07, 5'h0F, 5'h1F, 5'h01, 5'h1F};
    localparam logic [4:0]         WM [6]  = '{5'h01, 5'h07, 5'h0F, 5'h1F, 5'h00, 5'h00};

    pwp_param_bank pwp_param_bank_inst (
        .clk              (clk),
        .rst_n            (rst_n),
        .bus_req          (bus_req),
        .ctrl_reset_pin   (ctrl_reset_pin),
        .power_cycle_pin  (power_cycle_pin),
        .rd_data_q        (rd_data_q),
        .access_refused_q (access_refused_q),
        .wp_level_q       (wp_level_q),
        .apply_pending_q  (apply_pending_q),
        .basic_active     (basic_active)
    );

    pwp_ctrl_model pwp_ctrl_model_inst (
        .clk              (clk),
        .rd_data_q        (rd_data_q),
        .access_refused_q (access_refused_q),
        .bus_req          (bus_req),
        .ctrl_reset_pin   (ctrl_reset_pin),
        .power_cycle_pin  (power_cycle_pin)
    );

    // ==========================================
    // Compare and closing
    task automatic chk_val(input logic [PARAM_W-1:0] got, input logic [PARAM_W-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        #(40 * 20000);
        n_errors++;
        tally_and_finish();
    end

    // ==========================================
    // Main sequence
    initial
    begin
        logic [PARAM_W-1:0] q;
        logic               rf;
        logic [PARAM_W-1:0] d;
        logic [NUM_W-1:0]   n;
        logic [PARAM_W-1:0] ex [5];
        rst_n = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk_val(wp_level_q, 16'h000D);
        for (int k = 0; k < 10; k++)
        begin
            chk_val(basic_active[k], RVAL[k]);
            pwp_ctrl_model_inst.access(1'b0, GRP_BASIC, RNUM[k], 16'h0000, q, rf);
            chk_val(q, RVAL[k]);
        end
        // Unmapped places
        pwp_ctrl_model_inst.access(1'b0, GRP_BASIC, 5'h01, 16'h0000, q, rf);
        chk_flag(rf, 1'b1);
        chk_val(q, 16'h0000);
        pwp_ctrl_model_inst.access(1'b0, 3'h5, 5'h00, 16'h0000, q, rf);
        chk_flag(rf, 1'b1);
        ex = '{16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        // Every protect level against every group
        for (int i = 0; i < 6; i++)
        begin
            pwp_ctrl_model_inst.access(1'b1, GRP_BASIC, 5'h13, LVL[i], q, rf);
            chk_flag(rf, 1'b0);
            chk_val(wp_level_q, WP_FULL);
            pwp_ctrl_model_inst.apply(1'b0);
            chk_val(wp_level_q, LVL[i]);
            for (int g = 0; g < 5; g++)
            begin
                d = 16'hA000 | 16'(i * 16 + g);
                n = (g == 0) ? 5'h0A : 5'h07;
                pwp_ctrl_model_inst.access(1'b1, 3'(g), n, d, q, rf);
                chk_flag(rf, ~WM[i][g]);
                if (WM[i][g])
                    ex[g] = d;
                pwp_ctrl_model_inst.access(1'b0, 3'(g), n, 16'h0000, q, rf);
                chk_flag(rf, ~RM[i][g]);
                chk_val(q, RM[i][g] ? ex[g] : 16'h0000);
            end
            pwp_ctrl_model_inst.access(1'b1, GRP_BASIC, 5'h13, WP_FULL, q, rf);
            chk_flag(rf, 1'b0);
            pwp_ctrl_model_inst.apply(1'b0);
        end
        // Deferred apply of starred values
        pwp_ctrl_model_inst.access(1'b1, GRP_BASIC, 5'h02, 16'h0001, q, rf);
        pwp_ctrl_model_inst.access(1'b1, GRP_BASIC, 5'h03, 16'h0001, q, rf);
        repeat (3) @(posedge clk);
        #1;
        chk_val(basic_active[1], 16'h0000);
        chk_val(basic_active[0], 16'h0000);
        chk_flag(apply_pending_q, 1'b1);
        pwp_ctrl_model_inst.apply(1'b0);
        chk_val(basic_active[1], 16'h0001);
        chk_val(basic_active[0], 16'h0000);
        pwp_ctrl_model_inst.apply(1'b1);
        chk_val(basic_active[0], 16'h0001);
        chk_flag(apply_pending_q, 1'b0);
        tally_and_finish();
    end
endmodule // tb_pwp_param_bank
